// file: core/dram_bank_strobe_precharge.sv
`timescale 1ns/1ps
// How it works
// - Precharge enforced between accesses and refreshes
// - Two bits pick precharge and low counts
// - Low count for refresh; access follows request
// - One precharge counter per row strobe
// - Negation edge is one; hold until count
// - Pending strobe asserts on a clock edge
// - Refresh waits on access strobe precharge
// - Access after refresh waits on its own strobes
// - Config bits, bank and enables pick strobes
// - All-column layout: enables gate own strobe
// - Code 110: all columns, four row banks
// - Codes 000, 011: one bank; 000 scrubs
// - Codes 111, 010: four banks; 010 scrubs
// - Codes 101, 001: two banks; 001 scrubs
// - Another bank may start during this one's precharge
// - Burst toggles enables, latches stay open
module dram_bank_strobe_precharge
  import dram_strobe_pkg::*;
#(
  parameter int STROBES = STROBE_COUNT,
  parameter int CNT_WIDTH = EDGE_COUNT_WIDTH
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic accessRequestN,
  input wire logic refreshRequest,
  input wire logic [BANK_SEL_WIDTH-1:0] bankSelectIn,
  input wire logic [STROBES-1:0] columnEnableInN,
  input wire logic prechargeProgBit0,
  input wire logic prechargeProgBit1,
  input wire logic arrayCfgBitA,
  input wire logic arrayCfgBitB,
  input wire logic arrayCfgBitC,
  output logic [STROBES-1:0] rowStrobeN,
  output logic [STROBES-1:0] columnStrobeN,
  output logic accessHold,
  output logic refreshBusy,
  output logic refreshDone,
  output logic addressLatchOpen,
  output logic scrubPermitted
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    phase_t phase;
    logic [STROBES-1:0] rowOn;
    logic [STROBES-1:0] colOn;
    logic [STROBES-1:0] colSel;
    logic [CNT_WIDTH-1:0] lowCnt;
    logic hold;
    logic refreshDone;
    logic latchOpen;
    logic scrubOk;
    logic [STROBES-1:0] rowOutN;
    logic [STROBES-1:0] colOutN;
    logic busy;
  } ctl_state_t;

  ctl_state_t st_r;
  ctl_state_t st_nxt;

  logic [1:0] prechargeCode;
  logic [2:0] arrayCfg;
  logic [CNT_WIDTH-1:0] prechargeTarget;
  logic [CNT_WIDTH-1:0] lowTarget;
  logic [STROBES-1:0] prechargeDone;
  logic [2*STROBES-1:0] selection;
  logic [STROBES-1:0] rowSel;
  logic [STROBES-1:0] colSelNow;
  logic accessWanted;
  logic bankReady;
  logic allReady;

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic [CNT_WIDTH-1:0] precharge_edges(input logic [1:0] code);
    logic [CNT_WIDTH-1:0] edges;
    edges = CNT_WIDTH'(PRECHARGE_EDGES_0);
    case (code)
      2'h1: edges = CNT_WIDTH'(PRECHARGE_EDGES_1);
      2'h2: edges = CNT_WIDTH'(PRECHARGE_EDGES_2);
      2'h3: edges = CNT_WIDTH'(PRECHARGE_EDGES_3);
      default: edges = CNT_WIDTH'(PRECHARGE_EDGES_0);
    endcase
    return edges;
  endfunction

  function automatic logic [CNT_WIDTH-1:0] row_low_edges(input logic [1:0] code);
    logic [CNT_WIDTH-1:0] edges;
    edges = CNT_WIDTH'(ROW_LOW_EDGES_0);
    case (code)
      2'h1: edges = CNT_WIDTH'(ROW_LOW_EDGES_1);
      2'h2: edges = CNT_WIDTH'(ROW_LOW_EDGES_2);
      2'h3: edges = CNT_WIDTH'(ROW_LOW_EDGES_3);
      default: edges = CNT_WIDTH'(ROW_LOW_EDGES_0);
    endcase
    return edges;
  endfunction

  // Returns {row mask, column mask} for one access
  function automatic logic [7:0] strobe_select(input logic [2:0] cfg,
                                               input logic [1:0] bank);
    logic [3:0] oneHot;
    logic [3:0] pair;
    logic [7:0] sel;
    oneHot = ONE_STROBE << bank;
    pair = bank[0] ? (STROBE_PAIR << 2) : STROBE_PAIR;
    sel = {ALL_STROBES, ALL_STROBES};
    if (cfg == CFG_FOUR_BANK_BYTE) begin
      sel = {oneHot, ALL_STROBES};
    end else if (cfg == CFG_FOUR_BANK) begin
      sel = {oneHot, oneHot};
    end else if (cfg == CFG_FOUR_BANK_SCRUB) begin
      sel = {oneHot, oneHot};
    end else if (cfg == CFG_TWO_BANK) begin
      sel = {pair, pair};
    end else if (cfg == CFG_TWO_BANK_SCRUB) begin
      sel = {pair, pair};
    end else if (cfg == CFG_ONE_BANK) begin
      sel = {ALL_STROBES, ALL_STROBES};
    end else if (cfg == CFG_ONE_BANK_SCRUB) begin
      sel = {ALL_STROBES, ALL_STROBES};
    end else begin
      // Unlisted code 100 falls back to one bank, the wiring that can
      // never leave a column strobe low on an unselected row
      sel = {ALL_STROBES, ALL_STROBES};
    end
    return sel;
  endfunction

  function automatic logic scrub_allowed(input logic [2:0] cfg);
    return (cfg == CFG_ONE_BANK_SCRUB) || (cfg == CFG_TWO_BANK_SCRUB) ||
           (cfg == CFG_FOUR_BANK_SCRUB);
  endfunction

  // ****************************************
  // Programming and selection
  // ****************************************
  assign prechargeCode = {prechargeProgBit1, prechargeProgBit0};
  assign arrayCfg = {arrayCfgBitC, arrayCfgBitB, arrayCfgBitA};
  assign prechargeTarget = precharge_edges(prechargeCode);
  assign lowTarget = row_low_edges(prechargeCode);
  assign selection = 8'(strobe_select(arrayCfg, bankSelectIn));
  assign rowSel = selection[2*STROBES-1:STROBES];
  assign colSelNow = selection[STROBES-1:0];
  assign accessWanted = !accessRequestN;

  // Only the strobes this access uses must be precharged
  assign bankReady = &(prechargeDone | ~rowSel);
  assign allReady = &prechargeDone;

  // ****************************************
  // Per-strobe precharge counters
  // ****************************************
  for (genvar i = 0; i < STROBES; i++) begin : g_pre
    precharge_counter #(
      .WIDTH(CNT_WIDTH)
    ) u_pre (
      .clock(clock),
      .srst(srst),
      .strobeOnNxt(st_nxt.rowOn[i]),
      .target(prechargeTarget),
      .satisfied(prechargeDone[i])
    );
  end

  // ****************************************
  // Strobe sequencing
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.refreshDone = 1'b0;
    st_nxt.scrubOk = scrub_allowed(arrayCfg);
    case (st_r.phase)
      ST_IDLE: begin
        st_nxt.rowOn = NO_STROBES;
        st_nxt.colOn = NO_STROBES;
        st_nxt.latchOpen = 1'b0;
        if (refreshRequest) begin
          // Refresh wins the idle slot; an access waits behind it
          st_nxt.hold = accessWanted;
          if (allReady) begin
            st_nxt.phase = ST_REFRESH;
            st_nxt.rowOn = ALL_STROBES;
            st_nxt.lowCnt = CNT_WIDTH'(EDGE_ONE);
          end
        end else if (accessWanted) begin
          if (bankReady) begin
            st_nxt.phase = ST_ACCESS;
            st_nxt.rowOn = rowSel;
            st_nxt.colSel = colSelNow;
            st_nxt.latchOpen = 1'b1;
            st_nxt.hold = 1'b0;
          end else begin
            st_nxt.hold = 1'b1;
          end
        end else begin
          st_nxt.hold = 1'b0;
        end
      end
      ST_ACCESS: begin
        if (accessWanted) begin
          // Row strobe lasts as long as the request; columns follow the
          // enables so bursts and byte writes need no extra cycle
          st_nxt.colOn = st_r.colSel & ~columnEnableInN;
          st_nxt.latchOpen = 1'b1;
          st_nxt.hold = 1'b0;
        end else begin
          // This edge is precharge edge one
          st_nxt.phase = ST_IDLE;
          st_nxt.rowOn = NO_STROBES;
          st_nxt.colOn = NO_STROBES;
          st_nxt.latchOpen = 1'b0;
          st_nxt.hold = 1'b0;
        end
      end
      ST_REFRESH: begin
        st_nxt.colOn = NO_STROBES;
        st_nxt.hold = accessWanted;
        if (st_r.lowCnt >= lowTarget) begin
          // All strobes, strobe 3 included, negate together and restart
          // their counters, so the next access waits a full precharge
          st_nxt.phase = ST_IDLE;
          st_nxt.rowOn = NO_STROBES;
          st_nxt.refreshDone = 1'b1;
        end else begin
          st_nxt.lowCnt = st_r.lowCnt + CNT_WIDTH'(EDGE_ONE);
        end
      end
      default: begin
        st_nxt.phase = ST_IDLE;
        st_nxt.rowOn = NO_STROBES;
        st_nxt.colOn = NO_STROBES;
      end
    endcase
    // Pin images are registered as well, so no gate sits between a flop
    // and a pin and the strobes reach the array without a glitch
    st_nxt.rowOutN = ~st_nxt.rowOn;
    st_nxt.colOutN = ~st_nxt.colOn;
    st_nxt.busy = (st_nxt.phase == ST_REFRESH);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= '{
        phase: ST_IDLE,
        rowOn: NO_STROBES,
        colOn: NO_STROBES,
        colSel: NO_STROBES,
        lowCnt: '0,
        hold: 1'b0,
        refreshDone: 1'b0,
        latchOpen: 1'b0,
        scrubOk: 1'b0,
        rowOutN: ALL_STROBES,
        colOutN: ALL_STROBES,
        busy: 1'b0
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs, all from flip-flops
  // ****************************************
  // Another bank may start during one bank's precharge: one access owns the strobes of
  // its own bank only, others keep their own counters
  assign rowStrobeN = st_r.rowOutN;
  assign columnStrobeN = st_r.colOutN;
  assign accessHold = st_r.hold;
  assign refreshBusy = st_r.busy;
  assign refreshDone = st_r.refreshDone;
  assign addressLatchOpen = st_r.latchOpen;
  assign scrubPermitted = st_r.scrubOk;

endmodule

// file: core/precharge_counter.sv
`timescale 1ns/1ps
module precharge_counter
  import dram_strobe_pkg::*;
#(
  parameter int WIDTH = EDGE_COUNT_WIDTH
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic strobeOnNxt,
  input wire logic [WIDTH-1:0] target,
  output logic satisfied
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } cnt_state_t;

  cnt_state_t st_r;
  cnt_state_t st_nxt;

  // Edges are counted only while the strobe stays negated; the edge that
  // negates it is edge one
  always_comb begin
    st_nxt = st_r;
    if (strobeOnNxt) begin
      st_nxt.count = '0;
    end else if (st_r.count < target) begin
      st_nxt.count = st_r.count + WIDTH'(1);
    end
  end

  // Saturated at reset so the first access is never held
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= '{count: {WIDTH{1'b1}}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign satisfied = (st_r.count >= target);

endmodule

// file: inc/dram_strobe_pkg.sv
package dram_strobe_pkg;

  // ****************************************
  // Strobe geometry
  // ****************************************
  localparam int STROBE_COUNT = 4;
  localparam int BANK_SEL_WIDTH = 2;
  localparam int EDGE_COUNT_WIDTH = 4;
  localparam logic [3:0] ALL_STROBES = 4'hf;
  localparam logic [3:0] NO_STROBES = 4'h0;
  localparam logic [3:0] ONE_STROBE = 4'h1;
  localparam logic [3:0] STROBE_PAIR = 4'h3;
  localparam logic [3:0] COUNT_SATURATED = 4'hf;
  localparam logic [3:0] EDGE_ONE = 4'h1;

  // ****************************************
  // Precharge and refresh low edge counts, per precharge code
  // ****************************************
  localparam logic [3:0] PRECHARGE_EDGES_0 = 4'h2;
  localparam logic [3:0] PRECHARGE_EDGES_1 = 4'h2;
  localparam logic [3:0] PRECHARGE_EDGES_2 = 4'h3;
  localparam logic [3:0] PRECHARGE_EDGES_3 = 4'h3;
  localparam logic [3:0] ROW_LOW_EDGES_0 = 4'h3;
  localparam logic [3:0] ROW_LOW_EDGES_1 = 4'h4;
  localparam logic [3:0] ROW_LOW_EDGES_2 = 4'h4;
  localparam logic [3:0] ROW_LOW_EDGES_3 = 4'h5;

  // ****************************************
  // Array configuration codes, bits c,b,a
  // ****************************************
  localparam logic [2:0] CFG_ONE_BANK_SCRUB = 3'h0;
  localparam logic [2:0] CFG_TWO_BANK_SCRUB = 3'h1;
  localparam logic [2:0] CFG_FOUR_BANK_SCRUB = 3'h2;
  localparam logic [2:0] CFG_ONE_BANK = 3'h3;
  localparam logic [2:0] CFG_TWO_BANK = 3'h5;
  localparam logic [2:0] CFG_FOUR_BANK_BYTE = 3'h6;
  localparam logic [2:0] CFG_FOUR_BANK = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_REFRESH = 2'b10
  } phase_t;

endpackage

// file: testbench/dram_bank_strobe_precharge_tb.sv
`timescale 1ns/1ps
module dram_bank_strobe_precharge_tb;
  import dram_strobe_pkg::*;
  logic clock = 1'b0, srst = 1'b1, refreshRequest = 1'b0, go = 1'b0;
  logic prechargeProgBit0 = 1'b0, prechargeProgBit1 = 1'b0;
  logic arrayCfgBitA = 1'b0, arrayCfgBitB = 1'b0, arrayCfgBitC = 1'b0;
  logic [1:0] bankSelectIn = 2'h0;
  logic [3:0] columnEnableInN = 4'hf, holdCycles = 4'h1, m;
  logic [31:0] lfsrState = 32'h14a7974d;
  logic [3:0] rowStrobeN, columnStrobeN;
  logic accessRequestN, accessHold, refreshBusy, refreshDone, addressLatchOpen, scrubPermitted;
  int mismatches = 0, n_compared = 0, cycles = 0, n, addr;
  int prechTab [4] = '{2, 2, 3, 3};
  int lowTab [4] = '{3, 4, 4, 5};
  dram_bank_strobe_precharge dut (.clock, .srst, .accessRequestN, .refreshRequest,
    .bankSelectIn, .columnEnableInN, .prechargeProgBit0, .prechargeProgBit1, .arrayCfgBitA,
    .arrayCfgBitB, .arrayCfgBitC, .rowStrobeN, .columnStrobeN, .accessHold, .refreshBusy,
    .refreshDone, .addressLatchOpen, .scrubPermitted);
  host_access_model host (.clock, .go, .holdCycles, .latchOpen(addressLatchOpen),
    .accessRequestN);
  // ****************
  // Reference model and tasks
  // ****************
  function automatic logic [3:0] rowMask(input int cfg, input int bank);
    if (cfg inside {2, 6, 7}) return 4'h1 << bank;
    if (cfg inside {1, 5}) return bank[0] ? 4'hc : 4'h3;
    return 4'hf;
  endfunction
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], ^(s & 32'h80200003)};
  endfunction
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic span(input logic [3:0] mask, input logic [3:0] level);
    for (n = 0; n < 20 && (rowStrobeN & mask) === level; n++) @(negedge clock);
  endtask
  task automatic idle();
    span(4'hf, 4'h0);
    // Longest precharge is three edges, so four quiet cycles clear every counter
    repeat (4) @(negedge clock);
  endtask
  task automatic request(input int bank, input logic [3:0] hold, input logic refresh);
    bankSelectIn <= bank[1:0];
    holdCycles <= hold;
    refreshRequest <= refresh;
    go <= 1'b1;
    @(negedge clock);
    go <= 1'b0;
  endtask
  task automatic gap(input int b2, input int exp);
    @(negedge clock);
    request(0, 4'h0, 1'b0);
    for (int i = 0; i < 20 && addressLatchOpen !== 1'b1; i++) @(negedge clock);
    request(b2, 4'h0, 1'b0);
    m = rowMask(7, b2);
    span(m, m);
    check("gap", n[3:0], exp[3:0]);
    idle();
  endtask
  initial forever #4 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(negedge clock);
    srst <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      for (int b = 0; b < 4; b++) begin
        {arrayCfgBitC, arrayCfgBitB, arrayCfgBitA} <= c[2:0];
        lfsrState = lfsrNext(lfsrState);
        // Scrub layouts move whole words, so half their accesses pin every enable low
        columnEnableInN <= (c < 3 && b[0]) ? 4'h0 : lfsrState[3:0];
        // Odd codes take the bank from nibble address bits, even ones from page bits
        addr = c[0] ? b << 4 : b << 10;
        @(negedge clock);
        request(c[0] ? addr[5:4] : addr[11:10], 4'h1, 1'b0);
        for (int i = 0; i < 20 && addressLatchOpen !== 1'b1; i++) @(negedge clock);
        check("rows", rowStrobeN, ~rowMask(c, b));
        m = c == 6 ? 4'hf : rowMask(c, b);
        @(negedge clock);
        check("cols", columnStrobeN, ~(~columnEnableInN & m));
        check("scrub", {3'h0, scrubPermitted}, {3'h0, c < 3});
        idle();
      end
    end
    for (int p = 0; p < 4; p++) begin
      {prechargeProgBit1, prechargeProgBit0} <= p[1:0];
      gap(0, prechTab[p]);
      gap(1, 1);
      request(0, 4'h0, 1'b1);
      refreshRequest <= 1'b0;
      check("busy", {3'h0, refreshBusy}, 4'h1);
      span(4'hf, 4'h0);
      check("low", n[3:0], lowTab[p][3:0]);
      check("done", {1'b0, addressLatchOpen, refreshDone, accessHold}, 4'h3);
      span(4'h1, 4'h1);
      check("after", n[3:0], prechTab[p][3:0]);
      idle();
    end
    give_verdict();
  end
endmodule

// file: testbench/dram_strobe_sva.sv
`timescale 1ns/1ps
module dram_strobe_sva
  import dram_strobe_pkg::*;
#(
  parameter int STROBES = STROBE_COUNT
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic accessRequestN,
  input wire logic [STROBES-1:0] columnEnableInN,
  input wire logic prechargeProgBit0,
  input wire logic prechargeProgBit1,
  input wire logic arrayCfgBitA,
  input wire logic arrayCfgBitB,
  input wire logic arrayCfgBitC,
  input wire logic [STROBES-1:0] rowStrobeN,
  input wire logic [STROBES-1:0] columnStrobeN,
  input wire logic refreshBusy,
  input wire logic refreshDone,
  input wire logic addressLatchOpen,
  input wire logic scrubPermitted
);
  // ****************
  // Strobe checks
  // ****************
  localparam logic [3:0] LOW_TAB [4] = '{ROW_LOW_EDGES_0, ROW_LOW_EDGES_1,
    ROW_LOW_EDGES_2, ROW_LOW_EDGES_3};
  localparam logic [3:0] PRE_TAB [4] = '{PRECHARGE_EDGES_0, PRECHARGE_EDGES_1,
    PRECHARGE_EDGES_2, PRECHARGE_EDGES_3};
  logic [1:0] code;
  logic [3:0] busyCnt_r;
  logic [3:0] highCnt_r;
  assign code = {prechargeProgBit1, prechargeProgBit0};
  // High count starts saturated, matching counters that come out of reset satisfied
  always_ff @(posedge clock) begin
    if (srst) begin
      busyCnt_r <= 4'h0;
      highCnt_r <= 4'hf;
    end else begin
      busyCnt_r <= refreshBusy ? busyCnt_r + 4'h1 : 4'h0;
      highCnt_r <= !rowStrobeN[0] ? 4'h0 : (highCnt_r == 4'hf ? 4'hf : highCnt_r + 4'h1);
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_refresh_end;
    refreshBusy ##1 !refreshBusy;
  endsequence
  a_refresh_length: assert property ($fell(refreshBusy) |-> busyCnt_r == LOW_TAB[code])
    else $error("refresh low time");
  a_refresh_rows: assert property (refreshBusy |-> !rowStrobeN && &columnStrobeN)
    else $error("refresh strobes");
  a_refresh_end: assert property (s_refresh_end |-> refreshDone && &rowStrobeN)
    else $error("refresh end");
  a_done_cause: assert property (refreshDone |-> $past(refreshBusy))
    else $error("stray done");
  a_precharge_gap: assert property ($fell(rowStrobeN[0]) |-> highCnt_r >= PRE_TAB[code])
    else $error("precharge short");
  a_access_end: assert property ($rose(accessRequestN) && addressLatchOpen |=> &rowStrobeN)
    else $error("access not ended");
  a_col_follow: assert property (addressLatchOpen && $past(addressLatchOpen) |->
    !(~columnStrobeN & $past(columnEnableInN)))
    else $error("column without enable");
  a_scrub_code: assert property (!$past(srst) |-> scrubPermitted == (!$past(arrayCfgBitC)
    && !($past(arrayCfgBitB) && $past(arrayCfgBitA))))
    else $error("scrub flag");
endmodule
bind dram_bank_strobe_precharge dram_strobe_sva #(.STROBES(STROBES)) u_sva (.clock, .srst,
  .accessRequestN, .columnEnableInN, .prechargeProgBit0, .prechargeProgBit1, .arrayCfgBitA,
  .arrayCfgBitB, .arrayCfgBitC, .rowStrobeN, .columnStrobeN, .refreshBusy, .refreshDone,
  .addressLatchOpen, .scrubPermitted);

// file: testbench/host_access_model.sv
`timescale 1ns/1ps
module host_access_model (
  input wire logic clock,
  input wire logic go,
  input wire logic [3:0] holdCycles,
  input wire logic latchOpen,
  output logic accessRequestN
);
  int left = 0;
  bit pend = 1'b0;
  initial accessRequestN = 1'b1;
  always @(negedge clock) begin
    pend = pend | go;
    if (accessRequestN && pend) begin
      accessRequestN <= 1'b0;
      left = holdCycles;
      pend = 1'b0;
    end else if (!accessRequestN && latchOpen) begin
      // Release leaves a full idle cycle before any other bank is asked for
      if (left == 0) accessRequestN <= 1'b1;
      else left--;
    end
  end
endmodule
